/* verilog/remote_run_sync.sv */
`default_nettype none
module remote_run_sync
  import run_sync_pkg::*;
#(
  parameter int unsigned START_MIN = START_MIN_CYC,
  parameter int unsigned CONTACT = CONTACT_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Shared prepare line
  input wire logic prepare_in,
  // Shared start line
  input wire logic start_in,
  output logic start_out,
  output logic start_oe,
  // Shared stop line
  input wire logic stop_in,
  output logic stop_out,
  output logic stop_oe,
  // Shared ready line
  output logic ready_out,
  output logic ready_oe,
  // Isolated start contact
  output logic contact_closed,
  // Local instrument side
  input wire logic local_start,
  input wire logic local_stop,
  input wire logic local_ready,
  input wire logic run_done,
  output logic prep_active,
  output logic run_active
);

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers: ff1 read only by ff2
  logic [2:0] sync1;
  logic [2:0] sync2;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync1 <= 3'h7;
      sync2 <= 3'h7;
    end else begin
      sync1 <= {stop_in, start_in, prepare_in};
      sync2 <= sync1;
    end
  end
  // Active-low meanings, low level is zero
  logic prep_req;
  logic start_low;
  logic stop_req;
  assign prep_req = ~sync2[0];
  assign start_low = ~sync2[1];
  assign stop_req = ~sync2[2];

  ////////////////////////////////////////////////////////////////////////
  // Own start pull, seen back through the synchroniser, is no request
  logic pull_start;
  logic [2:0] own_hist;
  logic own_start;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      own_hist <= 3'h0;
    end else begin
      own_hist <= {own_hist[1:0], pull_start};
    end
  end
  // Covers the pull plus the synchroniser's lag after release
  assign own_start = pull_start || (own_hist != 3'h0);

  ////////////////////////////////////////////////////////////////////////
  // Start pulse width measurement
  logic [CNT_W-1:0] low_cnt;
  logic start_seen;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      low_cnt <= '0;
    end else if (!start_low || own_start) begin
      low_cnt <= '0;
    end else if (low_cnt < CNT_W'(START_MIN)) begin
      low_cnt <= low_cnt + 1'b1;
    end
  end
  // One pulse when the low has lasted long enough
  assign start_seen = start_low && (low_cnt == CNT_W'(START_MIN - 1));

  ////////////////////////////////////////////////////////////////////////
  // Run state machine
  run_state_t state;
  logic run_begin;
  assign run_begin = (state != ST_RUN) && !stop_req && !local_stop && (start_seen || local_start);
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (stop_req || local_stop) state <= ST_IDLE;
          else if (run_begin) state <= ST_RUN;
          else if (prep_req) state <= ST_PREP;
        end
        ST_PREP: begin
          if (stop_req || local_stop) state <= ST_IDLE;
          else if (run_begin) state <= ST_RUN;
        end
        ST_RUN: begin
          if (stop_req || local_stop || run_done) state <= ST_IDLE;
        end
      endcase
    end
  end
  assign prep_active = (state == ST_PREP);
  assign run_active = (state == ST_RUN);

  ////////////////////////////////////////////////////////////////////////
  // Start contact timer
  logic [CNT_W-1:0] contact_cnt;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      contact_cnt <= '0;
    end else if (run_begin) begin
      contact_cnt <= CNT_W'(CONTACT);
    end else if (contact_cnt != '0) begin
      contact_cnt <= contact_cnt - 1'b1;
    end
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      contact_closed <= 1'b0;
    end else begin
      contact_closed <= run_begin || (contact_cnt > CNT_W'(1));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Local start holds the shared line as long as a far start needs
  logic [CNT_W-1:0] drive_cnt;
  logic local_go;
  assign local_go = run_begin && local_start;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      drive_cnt <= '0;
    end else if (local_go) begin
      drive_cnt <= CNT_W'(START_MIN);
    end else if (drive_cnt != '0) begin
      drive_cnt <= drive_cnt - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Line drivers: output level always low, enable pulls
  logic pull_stop;
  logic pull_ready;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pull_start <= 1'b0;
      pull_stop <= 1'b0;
      pull_ready <= 1'b1;
    end else begin
      pull_start <= local_go || (drive_cnt > CNT_W'(1));
      pull_stop <= local_stop;
      pull_ready <= !(local_ready && (state != ST_RUN) && !run_begin);
    end
  end
  assign start_out = 1'b0;
  assign stop_out = 1'b0;
  assign ready_out = 1'b0;
  assign start_oe = pull_start;
  assign stop_oe = pull_stop;
  assign ready_oe = pull_ready;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_sync_delay;
    @(posedge mclk) disable iff (!nrst) $fell(sync2[1]) |-> $past(start_in, 2) == 1'b0;
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("start sync delay wrong");
  property p_short_pulse;
    @(posedge mclk) disable iff (!nrst) start_seen |-> $past(start_low, 1);
  endproperty
  a_short_pulse: assert property (p_short_pulse) else $error("start seen too early");
  property p_start_run;
    @(posedge mclk) disable iff (!nrst) run_begin |=> run_active;
  endproperty
  a_start_run: assert property (p_start_run) else $error("run did not begin");
  property p_contact_on;
    @(posedge mclk) disable iff (!nrst) run_begin |=> contact_closed;
  endproperty
  a_contact_on: assert property (p_contact_on) else $error("contact did not close");
  property p_contact_open;
    @(posedge mclk) disable iff (!nrst) (contact_cnt == CNT_W'(1)) && !run_begin |=> !contact_closed;
  endproperty
  a_contact_open: assert property (p_contact_open) else $error("contact stayed closed");
  property p_stop;
    @(posedge mclk) disable iff (!nrst) stop_req |=> !run_active;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not end run");
  property p_prep;
    @(posedge mclk) disable iff (!nrst) (state == ST_IDLE) && prep_req && !stop_req && !local_stop
      && !run_begin |=> prep_active;
  endproperty
  a_prep: assert property (p_prep) else $error("prepare not entered");
  property p_ready;
    @(posedge mclk) disable iff (!nrst) run_active |=> ready_oe;
  endproperty
  a_ready: assert property (p_ready) else $error("ready released during run");
  property p_open_drain;
    @(posedge mclk) disable iff (!nrst) !start_out && !stop_out && !ready_out;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("line driven high");
  property p_start_drive;
    @(posedge mclk) disable iff (!nrst) local_go |=> start_oe;
  endproperty
  a_start_drive: assert property (p_start_drive) else $error("local start not on line");
  c_ext_start: cover property (@(posedge mclk) disable iff (!nrst) start_seen ##1 run_active);
  c_prep_run: cover property (@(posedge mclk) disable iff (!nrst) prep_active ##1 run_active);
  c_stop_abort: cover property (@(posedge mclk) disable iff (!nrst) run_active ##1 stop_req ##1 !run_active);
endmodule : remote_run_sync
`default_nettype wire

/* verilog/run_sync_pkg.sv */
`default_nettype none
package run_sync_pkg;
  // Clock rate
  localparam int unsigned CLK_HZ = 25_000_000;
  // Least start pulse, microseconds
  localparam int unsigned START_MIN_US = 500;
  localparam int unsigned START_MIN_CYC = (START_MIN_US * (CLK_HZ / 1_000_000));
  // Start contact closure, milliseconds
  localparam int unsigned CONTACT_MS = 120;
  localparam int unsigned CONTACT_CYC = (CONTACT_MS * (CLK_HZ / 1_000));
  // Counter width
  localparam int unsigned CNT_W = 22;
  // Most instruments on the shared lines
  localparam int unsigned MAX_PARTIES = 10;
  // Run state
  typedef enum logic [1:0] {ST_IDLE, ST_PREP, ST_RUN} run_state_t;
endpackage : run_sync_pkg
`default_nettype wire

/* test/sync_partner.sv */
`default_nettype none
module sync_partner (
  // Pull requests from bench
  input wire logic pull_prep,
  input wire logic pull_start,
  input wire logic pull_stop,
  // Device pull enables
  input wire logic start_oe,
  input wire logic stop_oe,
  input wire logic ready_oe,
  // Device line data levels
  input wire logic start_out,
  input wire logic stop_out,
  input wire logic ready_out,
  // Line levels, passively pulled up
  output logic prep_line,
  output logic start_line,
  output logic stop_line,
  output logic ready_line
);
  timeunit 1ns;
  timeprecision 1ns;
  // Wired-low lines; this side only sinks
  assign prep_line = ~pull_prep;
  assign start_line = ~(pull_start | (start_oe & ~start_out));
  assign stop_line = ~(pull_stop | (stop_oe & ~stop_out));
  assign ready_line = ~(ready_oe & ~ready_out);
endmodule : sync_partner
`default_nettype wire

/* test/remote_run_sync_tb.sv */
`default_nettype none
module remote_run_sync_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, nrst, p_prep, p_start, p_stop, l_start, l_stop, l_ready, done;
  logic s_oe, t_oe, r_oe, prep_l, start_l, stop_l, ready_l, contact, prep_act, run_act;
  logic s_out, t_out, r_out;
  int failures, compares, n;
  // Far-side instrument
  sync_partner far (.pull_prep(p_prep), .pull_start(p_start), .pull_stop(p_stop), .start_oe(s_oe),
    .stop_oe(t_oe), .ready_oe(r_oe), .start_out(s_out), .stop_out(t_out), .ready_out(r_out),
    .prep_line(prep_l), .start_line(start_l), .stop_line(stop_l),
    .ready_line(ready_l));
  // Short counts: start 8 cycles, contact 20
  remote_run_sync #(.START_MIN(8), .CONTACT(20)) dut (.mclk(mclk), .nrst(nrst), .prepare_in(prep_l),
    .start_in(start_l), .start_out(s_out), .start_oe(s_oe), .stop_in(stop_l), .stop_out(t_out), .stop_oe(t_oe),
    .ready_out(r_out), .ready_oe(r_oe), .contact_closed(contact), .local_start(l_start), .local_stop(l_stop),
    .local_ready(l_ready), .run_done(done), .prep_active(prep_act), .run_active(run_act));
  task chk(input logic got, input logic exp, input string msg);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : chk
  // Step edges, then let updates land
  task cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : cyc
  task wait_run(input logic v);
    n = 0;
    while (run_act !== v && n < 30) begin
      cyc(1);
      n++;
    end
  endtask : wait_run
  task finish_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  // Start pulse below the minimum, then a long one
  task t_start;
    @(posedge mclk) p_start <= 1'b1;
    repeat (5) @(posedge mclk);
    p_start <= 1'b0;
    cyc(15);
    chk(run_act, 1'b0, "short pulse ran");
    @(posedge mclk) p_start <= 1'b1;
    repeat (12) @(posedge mclk);
    p_start <= 1'b0;
    wait_run(1'b1);
    chk(run_act, 1'b1, "no run");
    chk(contact, 1'b1, "contact open");
    chk(ready_l, 1'b0, "ready in run");
    n = 0;
    while (contact === 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    // Run began two edges before the pulse ended, so 20 less 2 remain
    chk(n == 18, 1'b1, "contact length");
    $display("start test done");
  endtask : t_start
  // Stop line ends the run
  task t_stop;
    @(posedge mclk) p_stop <= 1'b1;
    cyc(1);
    wait_run(1'b0);
    chk(n < 5, 1'b1, "slow stop");
    @(posedge mclk) p_stop <= 1'b0;
    cyc(4);
    chk(ready_l, 1'b1, "not ready");
    $display("stop test done");
  endtask : t_stop
  // Prepare, then local buttons drive lines
  task t_local;
    @(posedge mclk) p_prep <= 1'b1;
    cyc(5);
    chk(prep_act, 1'b1, "no prep");
    @(posedge mclk) p_prep <= 1'b0;
    l_start <= 1'b1;
    cyc(2);
    chk(start_l, 1'b0, "start line high");
    @(posedge mclk) l_start <= 1'b0;
    wait_run(1'b1);
    chk(run_act, 1'b1, "local run");
    @(posedge mclk) l_stop <= 1'b1;
    cyc(2);
    chk(stop_l, 1'b0, "stop line high");
    chk(run_act, 1'b0, "run kept");
    @(posedge mclk) l_stop <= 1'b0;
    cyc(12);
    @(posedge mclk) l_start <= 1'b1;
    @(posedge mclk) l_start <= 1'b0;
    wait_run(1'b1);
    chk(run_act, 1'b1, "second run");
    @(posedge mclk) done <= 1'b1;
    @(posedge mclk) done <= 1'b0;
    cyc(1);
    chk(run_act, 1'b0, "run outlived program");
    $display("local test done");
  endtask : t_local
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    #100000;
    failures++;
    finish_test;
  end
  // Reset, then the tests in turn
  initial begin
    {nrst, p_prep, p_start, p_stop, l_start, l_stop, done} = '0;
    l_ready = 1'b1;
    cyc(12);
    chk(ready_l, 1'b0, "ready in reset");
    @(posedge mclk) nrst <= 1'b1;
    cyc(3);
    t_start;
    t_stop;
    t_local;
    finish_test;
  end
endmodule : remote_run_sync_tb
`default_nettype wire
